// file: rtl/cmb_message_store.sv
// Function
// - sixteen control sets of eight RW bytes
// - sixteen payload sets of eight RW bytes
// - length code from control byte one bits 3:0
// - length code top bit means eight bytes
// - control byte five bit 4 selects remote
// - control byte five bit 3 selects extended
// - standard identifier split over bytes six, five
// - extended identifier over bytes five, eight, seven
// - reset leaves mailbox storage untouched
// - mailbox 0 receive only, others configurable
`timescale 1ns/1ps
`include "cmb_params.svh"
module cmb_message_store
   import cmb_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   output logic tx_hdr_valid,
   input wire logic tx_hdr_ready,
   output logic [`CMB_ID_W-1:0] tx_ident,
   output logic tx_ext_fmt,
   output logic tx_remote,
   output logic [3:0] tx_length_code,
   output logic tx_data_valid,
   input wire logic tx_data_ready,
   output logic [7:0] tx_data,
   output logic tx_done,
   input wire logic rx_hdr_valid,
   input wire logic [3:0] rx_mbox,
   input wire logic [`CMB_ID_W-1:0] rx_ident,
   input wire logic rx_ext_fmt,
   input wire logic rx_remote,
   input wire logic [3:0] rx_length_code,
   input wire logic rx_data_valid,
   input wire logic [7:0] rx_data,
   input wire logic rx_end,
   output logic rx_refused
);
   // mailbox storage: flip-flops without reset, contents undefined at power-up
   cmb_byte_t message_control_sets [`CMB_NUM_MBOX][`CMB_BYTES_PER_SET];
   cmb_byte_t message_payload_sets [`CMB_NUM_MBOX][`CMB_BYTES_PER_SET];

   logic [15:0] dir_rx;
   cmb_mbox_t tx_mbox;
   logic tx_start;
   logic tx_busy;
   logic [63:0] tx_ctrl_flat;
   logic [63:0] tx_data_flat;
   logic apb_access;
   logic wr_fire;
   logic in_mbox;
   cmb_mbox_t a_mbox;
   logic a_is_data;
   logic [2:0] a_idx;
   logic [31:0] next_prdata;
   logic next_pslverr;
   logic [15:0] rx_enabled;
   logic rx_active;
   cmb_mbox_t rx_wr_mbox;
   logic rx_hdr_we;
   logic [`CMB_ID_W-1:0] rx_wr_ident;
   logic rx_wr_ext;
   logic rx_wr_remote;
   logic [3:0] rx_wr_len;
   logic rx_byte_we;
   logic [2:0] rx_byte_idx;
   cmb_byte_t rx_byte_val;
   logic rx_refused_int;
   logic tx_hdr_valid_int;
   logic [`CMB_ID_W-1:0] tx_ident_int;
   logic tx_ext_int;
   logic tx_remote_int;
   logic [3:0] tx_len_int;
   logic tx_data_valid_int;
   cmb_byte_t tx_data_int;
   logic tx_done_int;

   // decoded enables and read words
   logic tx_cmd_we;
   logic tx_start_ok;
   logic dir_we;
   logic ctrl_sw_we;
   logic data_sw_we;
   cmb_byte_t mbox_rd_byte;
   logic [31:0] status_word;
   logic [31:0] tx_cmd_word;
   cmb_byte_t rx_flags_byte;

   // one decode shared by the read mux and the write paths
   function automatic logic reg_hit(input logic [11:0] a, input logic [11:0] offset);
      reg_hit = (a == offset);
   endfunction

   assign apb_access = psel && penable;
   // one wait state: pready is raised one cycle into the access phase
   assign wr_fire = apb_access && pready && pwrite;
   assign in_mbox = (paddr[11:10] == `CMB_MBOX_REGION);
   assign a_mbox = paddr[9:6];
   assign a_is_data = paddr[`CMB_DATA_SEL_BIT];
   assign a_idx = paddr[4:2];
   assign rx_enabled = {dir_rx[15:1], 1'b1};

   assign mbox_rd_byte = a_is_data ? message_payload_sets[a_mbox][a_idx]
                                   : message_control_sets[a_mbox][a_idx];
   assign status_word = {20'h0, rx_wr_mbox, tx_mbox, 2'h0, rx_active, tx_busy};
   assign tx_cmd_word = {23'h0, tx_busy, 4'h0, tx_mbox};

   // byte registers ride on lane 0 only
   assign ctrl_sw_we = wr_fire && in_mbox && pstrb[0] && !a_is_data;
   assign data_sw_we = wr_fire && in_mbox && pstrb[0] && a_is_data;
   assign dir_we = wr_fire && reg_hit(paddr, `CMB_REG_DIR);
   assign tx_cmd_we = wr_fire && reg_hit(paddr, `CMB_REG_TX_CMD) && pstrb[1] && pstrb[0];
   // start refused while busy or toward a receive mailbox
   assign tx_start_ok = tx_cmd_we && !tx_busy && pwdata[`CMB_TX_START_BIT] && !rx_enabled[pwdata[3:0]];
   // received flags byte keeps the reserved bit that software wrote
   assign rx_flags_byte = {rx_wr_ident[20:18], rx_wr_remote, rx_wr_ext,
                           message_control_sets[rx_wr_mbox][`CMB_B_FLAGS][`CMB_RSV_BIT], rx_wr_ident[17:16]};

   always_comb
   begin
      next_prdata = 32'h0;
      next_pslverr = 1'b0;
      if (in_mbox)
         next_prdata = {24'h0, mbox_rd_byte};
      else if (reg_hit(paddr, `CMB_REG_DIR))
         next_prdata = {16'h0, rx_enabled};
      else if (reg_hit(paddr, `CMB_REG_STATUS))
         next_prdata = status_word;
      else if (reg_hit(paddr, `CMB_REG_TX_CMD))
         next_prdata = tx_cmd_word;
      else
         next_pslverr = 1'b1;
   end

   // the answer stands in the second access cycle only
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         pready <= 1'b0;
      else
         pready <= apb_access && !pready;
   end

   // read data and error are zero except while pready is high
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata <= 32'h0;
         pslverr <= 1'b0;
      end
      else if (apb_access && !pready)
      begin
         prdata <= pwrite ? 32'h0 : next_prdata;
         pslverr <= next_pslverr;
      end
      else
      begin
         prdata <= 32'h0;
         pslverr <= 1'b0;
      end
   end

   // direction register; bit 0 is not stored, mailbox 0 always receives
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         dir_rx <= `CMB_DIR_RESET;
      else if (dir_we)
      begin
         if (pstrb[0])
            dir_rx[7:1] <= pwdata[7:1];
         if (pstrb[1])
            dir_rx[15:8] <= pwdata[15:8];
      end
   end

   // transmit command: one start pulse per accepted request
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         tx_mbox <= 4'h0;
         tx_start <= 1'b0;
      end
      else
      begin
         tx_start <= tx_start_ok;
         if (tx_start_ok)
            tx_mbox <= pwdata[3:0];
      end
   end

   // no reset here: a hardware reset must not disturb mailbox contents
   always_ff @(posedge pclk)
   begin
      if (ctrl_sw_we)
         message_control_sets[a_mbox][a_idx] <= pwdata[7:0];
      // a received header wins over a software write in the same cycle
      if (rx_hdr_we)
      begin
         message_control_sets[rx_wr_mbox][`CMB_B_LEN][3:0] <= rx_wr_len;
         message_control_sets[rx_wr_mbox][`CMB_B_FLAGS] <= rx_flags_byte;
         message_control_sets[rx_wr_mbox][`CMB_B_STD_HI] <= rx_wr_ident[28:21];
         message_control_sets[rx_wr_mbox][`CMB_B_EXT_LO] <= rx_wr_ident[7:0];
         message_control_sets[rx_wr_mbox][`CMB_B_EXT_MID] <= rx_wr_ident[15:8];
      end
   end

   // payload store, likewise left alone by reset
   always_ff @(posedge pclk)
   begin
      if (data_sw_we)
         message_payload_sets[a_mbox][a_idx] <= pwdata[7:0];
      // a received byte wins over a software write in the same cycle
      if (rx_byte_we)
         message_payload_sets[rx_wr_mbox][rx_byte_idx] <= rx_byte_val;
   end

   always_comb
   begin
      tx_ctrl_flat = 64'h0;
      tx_data_flat = 64'h0;
      for (int k = 0; k < `CMB_BYTES_PER_SET; k++)
      begin
         tx_ctrl_flat[8*k +: 8] = message_control_sets[tx_mbox][k];
         tx_data_flat[8*k +: 8] = message_payload_sets[tx_mbox][k];
      end
   end

   cmb_tx_reader u_tx
   (
      .clk(pclk),
      .rst_n(presetn),
      .start(tx_start),
      .ctrl_set(tx_ctrl_flat),
      .data_set(tx_data_flat),
      .hdr_ready(tx_hdr_ready),
      .data_ready(tx_data_ready),
      .busy(tx_busy),
      .hdr_valid(tx_hdr_valid_int),
      .ident(tx_ident_int),
      .ext_fmt(tx_ext_int),
      .remote(tx_remote_int),
      .len_code(tx_len_int),
      .data_valid(tx_data_valid_int),
      .data(tx_data_int),
      .done(tx_done_int)
   );

   cmb_rx_writer u_rx
   (
      .clk(pclk),
      .rst_n(presetn),
      .rx_enabled(rx_enabled),
      .hdr_in(rx_hdr_valid),
      .mbox_in(rx_mbox),
      .ident_in(rx_ident),
      .ext_in(rx_ext_fmt),
      .remote_in(rx_remote),
      .len_in(rx_length_code),
      .byte_in_valid(rx_data_valid),
      .byte_in(rx_data),
      .frame_end(rx_end),
      .active(rx_active),
      .mbox(rx_wr_mbox),
      .hdr_we(rx_hdr_we),
      .ident(rx_wr_ident),
      .ext_fmt(rx_wr_ext),
      .remote(rx_wr_remote),
      .len_code(rx_wr_len),
      .byte_we(rx_byte_we),
      .byte_idx(rx_byte_idx),
      .byte_val(rx_byte_val),
      .refused(rx_refused_int)
   );

   // sub-module outputs are flip-flops already; plain wiring to the pins
   assign tx_hdr_valid = tx_hdr_valid_int;
   assign tx_ident = tx_ident_int;
   assign tx_ext_fmt = tx_ext_int;
   assign tx_remote = tx_remote_int;
   assign tx_length_code = tx_len_int;
   assign tx_data_valid = tx_data_valid_int;
   assign tx_data = tx_data_int;
   assign tx_done = tx_done_int;
   assign rx_refused = rx_refused_int;
endmodule // cmb_message_store

// file: rtl/cmb_params.svh
`ifndef CMB_PARAMS_SVH
`define CMB_PARAMS_SVH
`define CMB_NUM_MBOX 16
`define CMB_BYTES_PER_SET 8
`define CMB_MAX_LEN 4'h8
`define CMB_MBOX_REGION 2'h0
`define CMB_DATA_SEL_BIT 5
`define CMB_REG_DIR 12'h400
`define CMB_REG_STATUS 12'h404
`define CMB_REG_TX_CMD 12'h408
`define CMB_DIR_RESET 16'h0000
`define CMB_RX_ONLY_MBOX 4'h0
`define CMB_TX_START_BIT 8
`define CMB_B_LEN 3'h0
`define CMB_B_FLAGS 3'h4
`define CMB_B_STD_HI 3'h5
`define CMB_B_EXT_LO 3'h6
`define CMB_B_EXT_MID 3'h7
`define CMB_LEN_MSB 3
`define CMB_RTR_BIT 4
`define CMB_IDE_BIT 3
`define CMB_RSV_BIT 2
`define CMB_ID_W 29
`define CMB_EXT_W 18
`endif

// file: rtl/cmb_pkg.sv
`include "cmb_params.svh"
package cmb_pkg;
   typedef logic [7:0] cmb_byte_t;
   typedef logic [3:0] cmb_mbox_t;
   typedef enum logic [1:0] {CMB_TX_IDLE, CMB_TX_HDR, CMB_TX_DATA} cmb_tx_state_e;

   // top length bit forces eight bytes, low bits then ignored
   function automatic logic [3:0] cmb_eff_len(input logic [3:0] code);
      cmb_eff_len = code[`CMB_LEN_MSB] ? `CMB_MAX_LEN : {1'b0, code[2:0]};
   endfunction
endpackage

// file: rtl/cmb_tx_reader.sv
`timescale 1ns/1ps
`include "cmb_params.svh"
module cmb_tx_reader
   import cmb_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic start,
   input wire logic [63:0] ctrl_set,
   input wire logic [63:0] data_set,
   input wire logic hdr_ready,
   input wire logic data_ready,
   output logic busy,
   output logic hdr_valid,
   output logic [`CMB_ID_W-1:0] ident,
   output logic ext_fmt,
   output logic remote,
   output logic [3:0] len_code,
   output logic data_valid,
   output cmb_byte_t data,
   output logic done
);
   cmb_tx_state_e state;
   logic [63:0] shift;
   logic [3:0] nbytes;
   logic [3:0] sent;

   assign busy = (state != CMB_TX_IDLE);

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state <= CMB_TX_IDLE;
         shift <= 64'h0;
         nbytes <= 4'h0;
         sent <= 4'h0;
         hdr_valid <= 1'b0;
         ident <= '0;
         ext_fmt <= 1'b0;
         remote <= 1'b0;
         len_code <= 4'h0;
         data_valid <= 1'b0;
         data <= 8'h00;
         done <= 1'b0;
      end
      else
      begin
         done <= 1'b0;
         case (state)
            CMB_TX_IDLE:
               if (start)
               begin
                  // snapshot, so later software writes cannot tear the frame
                  shift <= data_set;
                  len_code <= ctrl_set[3:0];
                  remote <= ctrl_set[32 + `CMB_RTR_BIT];
                  ext_fmt <= ctrl_set[32 + `CMB_IDE_BIT];
                  ident <= {ctrl_set[47:40], ctrl_set[39:37], ctrl_set[33:32], ctrl_set[63:48]};
                  nbytes <= ctrl_set[32 + `CMB_RTR_BIT] ? 4'h0 : cmb_eff_len(ctrl_set[3:0]);
                  hdr_valid <= 1'b1;
                  state <= CMB_TX_HDR;
               end
            CMB_TX_HDR:
               if (hdr_ready)
               begin
                  hdr_valid <= 1'b0;
                  sent <= 4'h1;
                  if (nbytes == 4'h0)
                  begin
                     done <= 1'b1;
                     state <= CMB_TX_IDLE;
                  end
                  else
                  begin
                     data <= shift[7:0];
                     data_valid <= 1'b1;
                     state <= CMB_TX_DATA;
                  end
               end
            CMB_TX_DATA:
               if (data_ready)
               begin
                  if (sent == nbytes)
                  begin
                     data_valid <= 1'b0;
                     done <= 1'b1;
                     state <= CMB_TX_IDLE;
                  end
                  else
                  begin
                     data <= shift[15:8];
                     shift <= {8'h00, shift[63:8]};
                     sent <= sent + 4'h1;
                  end
               end
            default:
               state <= CMB_TX_IDLE;
         endcase
      end
   end
endmodule // cmb_tx_reader

// file: rtl/cmb_rx_writer.sv
`timescale 1ns/1ps
`include "cmb_params.svh"
module cmb_rx_writer
   import cmb_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [15:0] rx_enabled,
   input wire logic hdr_in,
   input wire cmb_mbox_t mbox_in,
   input wire logic [`CMB_ID_W-1:0] ident_in,
   input wire logic ext_in,
   input wire logic remote_in,
   input wire logic [3:0] len_in,
   input wire logic byte_in_valid,
   input wire cmb_byte_t byte_in,
   input wire logic frame_end,
   output logic active,
   output cmb_mbox_t mbox,
   output logic hdr_we,
   output logic [`CMB_ID_W-1:0] ident,
   output logic ext_fmt,
   output logic remote,
   output logic [3:0] len_code,
   output logic byte_we,
   output logic [2:0] byte_idx,
   output cmb_byte_t byte_val,
   output logic refused
);
   logic [3:0] limit;
   logic [3:0] count;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         active <= 1'b0;
         mbox <= 4'h0;
         hdr_we <= 1'b0;
         ident <= '0;
         ext_fmt <= 1'b0;
         remote <= 1'b0;
         len_code <= 4'h0;
         byte_we <= 1'b0;
         byte_idx <= 3'h0;
         byte_val <= 8'h00;
         refused <= 1'b0;
         limit <= 4'h0;
         count <= 4'h0;
      end
      else
      begin
         hdr_we <= 1'b0;
         byte_we <= 1'b0;
         refused <= 1'b0;
         if (hdr_in)
         begin
            // transmit mailboxes never take a received frame
            if (rx_enabled[mbox_in])
            begin
               active <= 1'b1;
               mbox <= mbox_in;
               hdr_we <= 1'b1;
               ident <= ident_in;
               ext_fmt <= ext_in;
               remote <= remote_in;
               len_code <= len_in;
               limit <= remote_in ? 4'h0 : cmb_eff_len(len_in);
               count <= 4'h0;
            end
            else
            begin
               active <= 1'b0;
               refused <= 1'b1;
            end
         end
         else if (frame_end)
            active <= 1'b0;
         else if (byte_in_valid && active && count < limit)
         begin
            byte_we <= 1'b1;
            byte_idx <= count[2:0];
            byte_val <= byte_in;
            count <= count + 4'h1;
         end
      end
   end
endmodule // cmb_rx_writer

// file: verification/cmb_store_checker.sv
`timescale 1ns/1ps
module cmb_store_checker
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic tx_hdr_valid,
   input wire logic tx_hdr_ready,
   input wire logic tx_remote,
   input wire logic [3:0] tx_length_code,
   input wire logic tx_data_valid,
   input wire logic tx_data_ready,
   input wire logic [7:0] tx_data,
   input wire logic tx_done,
   input wire logic rx_hdr_valid,
   input wire logic [3:0] rx_mbox,
   input wire logic rx_refused
);
   logic [3:0] cnt, lim;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // bytes sent since the header, against the length it announced
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cnt <= 4'h0;
         lim <= 4'h0;
      end
      else if (tx_hdr_valid && tx_hdr_ready)
      begin
         cnt <= 4'h0;
         lim <= tx_remote ? 4'h0 : (tx_length_code[3] ? 4'h8 : {1'b0, tx_length_code[2:0]});
      end
      else if (tx_data_valid && tx_data_ready)
         cnt <= cnt + 4'h1;
   end
   a_ready_second: assert property (psel && $rose(penable) |=> pready)
      else $error("pready late");
   a_error_flag: assert property (pslverr |-> pready && psel && penable)
      else $error("stray pslverr");
   a_hdr_hold: assert property (tx_hdr_valid && !tx_hdr_ready |=> tx_hdr_valid && $stable(tx_length_code))
      else $error("header dropped");
   a_byte_hold: assert property (tx_data_valid && !tx_data_ready |=> tx_data_valid && $stable(tx_data))
      else $error("byte dropped");
   a_no_payload: assert property (tx_hdr_valid && tx_hdr_ready && (tx_remote || tx_length_code == 4'h0)
      |=> tx_done && !tx_data_valid) else $error("bytes after empty header");
   a_first_byte: assert property (tx_hdr_valid && tx_hdr_ready && !tx_remote && tx_length_code != 4'h0
      |=> tx_data_valid) else $error("first byte late");
   a_len_count: assert property (tx_done |-> cnt == lim)
      else $error("byte count wrong");
   a_refuse_cause: assert property (rx_refused |-> $past(rx_hdr_valid) && $past(rx_mbox) != 4'h0)
      else $error("refusal without cause");
   cover property (tx_done && lim == 4'h8);
   cover property (rx_refused);
   cover property (pslverr);
endmodule // cmb_store_checker

bind cmb_message_store cmb_store_checker chk_i (.pclk, .presetn, .psel, .penable, .pready, .pslverr,
   .tx_hdr_valid, .tx_hdr_ready, .tx_remote, .tx_length_code, .tx_data_valid, .tx_data_ready, .tx_data,
   .tx_done, .rx_hdr_valid, .rx_mbox, .rx_refused);

// file: verification/cmb_engine_model.sv
`timescale 1ns/1ps
module cmb_engine_model
(
   input wire logic clk,
   input wire logic slow,
   output logic hdr_ready,
   output logic data_ready
);
   // a slow engine stalls at random, so offers must be held
   always @(posedge clk)
   begin
      hdr_ready <= slow ? 1'($urandom) : 1'b1;
      data_ready <= slow ? 1'($urandom) : 1'b1;
   end
endmodule // cmb_engine_model

// file: verification/test_can_mailbox_message_store.sv
`timescale 1ns/1ps
`include "cmb_params.svh"
module test_can_mailbox_message_store;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, slow;
   logic tx_hdr_valid, tx_hdr_ready, tx_ext_fmt, tx_remote, tx_data_valid, tx_data_ready, tx_done;
   logic rx_hdr_valid, rx_ext_fmt, rx_remote, rx_data_valid, rx_end, rx_refused;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [3:0] pstrb, tx_length_code, rx_mbox, rx_length_code;
   logic [`CMB_ID_W-1:0] tx_ident, rx_ident;
   logic [7:0] tx_data, rx_data;
   logic [7:0] mem [16][16];
   logic [63:0] rq[$], hq[$], dq[$], fq[$];
   logic [34:0] h;
   logic [63:0] d;
   int error_cnt, num_checks, m, k, n;
   int rxm[6] = '{0, 4, 5, 7, 2, 6};

   cmb_message_store uut (.*);
   cmb_engine_model eng (.clk(pclk), .slow(slow), .hdr_ready(tx_hdr_ready), .data_ready(tx_data_ready));

   always #4 pclk = ~pclk;

   task automatic report_and_stop;
      if (error_cnt == 0 && num_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
      num_checks++;
      if (e !== g)
      begin
         error_cnt++;
         $display("MISMATCH %s exp %h got %h", nm, e, g);
      end
   endtask

   task automatic give_up(input int c);
      if (c >= 300)
      begin
         chk("timeout", 64'h1, 64'h0);
         report_and_stop();
      end
   endtask

   task automatic apb(input logic w, input int a, input logic [31:0] wd);
      int c;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= 12'(a);
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      c = 0;
      do
         @(posedge pclk);
      while (pready !== 1'b1 && ++c < 300);
      give_up(c);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd(input int a, input logic [32:0] e);
      rq.push_back(64'(e));
      apb(1'b0, a, 32'h0);
   endtask

   // header lines turn over once the pulse is gone
   task automatic rx_frame(input logic [3:0] mb);
      @(posedge pclk);
      rx_hdr_valid <= 1'b1;
      rx_mbox <= mb;
      {rx_ext_fmt, rx_remote, rx_length_code, rx_ident} <= h;
      for (int i = 0; i < 8; i++)
      begin
         @(posedge pclk);
         rx_hdr_valid <= 1'b0;
         rx_mbox <= ~mb;
         {rx_ext_fmt, rx_remote, rx_length_code, rx_ident} <= ~h;
         rx_data_valid <= 1'b1;
         rx_data <= d[8*i +: 8];
      end
      @(posedge pclk);
      rx_data_valid <= 1'b0;
      rx_data <= ~rx_data;
      rx_end <= 1'b1;
      @(posedge pclk);
      rx_end <= 1'b0;
   endtask

   task automatic cmp_read(input logic [32:0] g);
      chk("prdata", rq.size() ? rq.pop_front() : 'x, 64'(g));
   endtask

   task automatic cmp_header(input logic [34:0] g);
      chk("header", hq.size() ? hq.pop_front() : 'x, 64'(g));
   endtask

   task automatic cmp_byte(input logic [7:0] g);
      chk("payload", dq.size() ? dq.pop_front() : 'x, 64'(g));
   endtask

   task automatic cmp_refused(input logic g);
      chk("refused", fq.size() ? fq.pop_front() : 'x, 64'(g));
   endtask

   // sampled at the handshake edge itself, before that edge's updates land
   always @(posedge pclk)
   begin
      if (psel && penable && pready === 1'b1 && !pwrite)
         cmp_read({pslverr, prdata});
      if (tx_hdr_valid === 1'b1 && tx_hdr_ready)
         cmp_header({tx_ext_fmt, tx_remote, tx_length_code, tx_ident});
      if (tx_data_valid === 1'b1 && tx_data_ready)
         cmp_byte(tx_data);
      if (rx_refused === 1'b1)
         cmp_refused(rx_refused);
   end

   initial
   begin
      {pclk, presetn, psel, penable, pwrite, paddr, pwdata, slow} = '0;
      {rx_hdr_valid, rx_ext_fmt, rx_remote, rx_data_valid, rx_end, rx_mbox, rx_length_code, rx_ident, rx_data} = '0;
      pstrb = 4'hF;
      void'($urandom(32'hB7C8));
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      for (m = 0; m < 16; m++)
         for (k = 0; k < 16; k++)
         begin
            mem[m][k] = 8'($urandom);
            apb(1'b1, m * 64 + k * 4, {24'h0, mem[m][k]});
         end
      rd(`CMB_REG_DIR, 33'h1);
      rd(12'h40C, 33'h1_0000_0000);
      // every length code, on three transmit mailboxes
      for (k = 0; k < 16; k++)
      begin
         m = k % 3 + 1;
         mem[m][0] = {mem[m][0][7:4], 4'(k)};
         apb(1'b1, m * 64, {24'h0, mem[m][0]});
         hq.push_back({mem[m][4][3], mem[m][4][4], mem[m][0][3:0], mem[m][5], mem[m][4][7:5], mem[m][4][1:0],
            mem[m][7], mem[m][6]});
         n = mem[m][4][4] ? 0 : (k > 7 ? 8 : k);
         for (int i = 0; i < n; i++)
            dq.push_back(64'(mem[m][8 + i]));
         slow <= k[0];
         apb(1'b1, `CMB_REG_TX_CMD, 32'h100 + 32'(m));
         n = 0;
         while (tx_done !== 1'b1 && n < 300)
         begin
            @(negedge pclk);
            n++;
         end
         give_up(n);
      end
      apb(1'b1, `CMB_REG_DIR, 32'hF0);
      rd(`CMB_REG_DIR, 33'hF1);
      apb(1'b1, `CMB_REG_TX_CMD, 32'h100);
      apb(1'b1, `CMB_REG_TX_CMD, 32'h104);
      // lane 0 off: byte write and start must both be ignored
      pstrb <= 4'hE;
      apb(1'b1, 3 * 64 + 4, 32'h0);
      apb(1'b1, `CMB_REG_TX_CMD, 32'h101);
      pstrb <= 4'hF;
      repeat (20) @(posedge pclk);
      for (k = 0; k < 6; k++)
      begin
         m = rxm[k];
         h = 35'({$urandom, $urandom});
         d = {$urandom, $urandom};
         if (m == 2)
            fq.push_back(64'h1);
         else
         begin
            mem[m][0][3:0] = h[32:29];
            mem[m][4] = {h[20:18], h[33], h[34], mem[m][4][2], h[17:16]};
            mem[m][5] = h[28:21];
            mem[m][6] = h[7:0];
            mem[m][7] = h[15:8];
            n = h[33] ? 0 : (h[32] ? 8 : h[31:29]);
            for (int i = 0; i < n; i++)
               mem[m][8 + i] = d[8*i +: 8];
         end
         rx_frame(4'(m));
      end
      rd(`CMB_REG_STATUS, 33'h610);
      rd(`CMB_REG_TX_CMD, 33'h1);
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      rd(`CMB_REG_DIR, 33'h1);
      for (m = 0; m < 16; m++)
         for (k = 0; k < 16; k++)
            rd(m * 64 + k * 4, {25'h0, mem[m][k]});
      repeat (4) @(posedge pclk);
      chk("pending", 64'h0, 64'(rq.size() + hq.size() + dq.size() + fq.size()));
      report_and_stop();
   end
endmodule // test_can_mailbox_message_store
